// File: inc/ilc_params.svh
// register indices, field positions, reset values and timing counts
`ifndef ILC_PARAMS_SVH
`define ILC_PARAMS_SVH
`define ILC_IDX_CODE_CTRL    8'hB6
`define ILC_IDX_TX_FIRST     8'hB7
`define ILC_IDX_TX_SECOND    8'hB8
`define ILC_IDX_UP_FIRST     8'hB9
`define ILC_IDX_UP_SECOND    8'hBA
`define ILC_IDX_DOWN_FIRST   8'hBB
`define ILC_IDX_DOWN_SECOND  8'hBC
`define ILC_IDX_SPARE_CTRL   8'hBD
`define ILC_IDX_SPARE_FIRST  8'hBE
`define ILC_IDX_SPARE_SECOND 8'hBF
`define ILC_IDX_LOOP_CTRL    8'hC0
`define ILC_IDX_LINE_MODE    8'hC1
`define ILC_IDX_STATUS_THREE 8'hC2
`define ILC_RST_BYTE         8'h00
`define ILC_TXLEN_LSB        6
`define ILC_UPLEN_LSB        3
`define ILC_DNLEN_LSB        0
`define ILC_LOOP_EN_BIT      0
`define ILC_MODE_T1_BIT      0
`define ILC_MODE_NOINS_BIT   1
`define ILC_STAT_UP_BIT      5
`define ILC_STAT_DOWN_BIT    6
`define ILC_STAT_SPARE_BIT   7
`define ILC_INTEG_MS         36
`define ILC_LINE_BPS         1544000
`define ILC_INTEG_BITS       ((`ILC_INTEG_MS * `ILC_LINE_BPS) / 1000)
`endif

// File: inc/ilc_pkg.sv
// shared types of the in-band loop code block
package ilc_pkg;
   typedef enum logic [1:0] {
      ILC_HUNT = 2'b00,
      ILC_LOCK = 2'b01
   } ilc_det_state_t;
   typedef logic [4:0] ilc_len_t;
endpackage

// File: inc/ilc_lane_if.sv
// one pattern lane between the control core and a generator or detector
interface ilc_lane_if;
   logic [15:0] code;
   logic [4:0]  len;
   logic        stb;
   logic        din;
   logic        slot;
   logic        run;
   logic        restart;
   logic        dout;
   modport ctl (output code, len, stb, din, slot, run, restart, input dout);
   modport gen (input code, len, stb, din, slot, run, output dout);
   modport det (input code, len, stb, din, run, restart, output dout);
endinterface

// File: verilog/ilc_tx_gen.sv
// transmit loop code generator
module ilc_tx_gen
   import ilc_pkg::*;
(
   input wire logic   mclk,
   input wire logic   rst,
   ilc_lane_if.gen    lane
);
   typedef struct packed {
      logic [3:0] phase;
      logic       dout;
   } ilc_gen_st_t;

   ilc_gen_st_t st;
   ilc_gen_st_t next_st;

   always_comb begin
      next_st = st;
      if (lane.stb) begin
         if (!lane.run || lane.slot) begin
            next_st.dout = lane.din;
         end else begin
            next_st.dout = lane.code[4'hF - st.phase];
         end
         if (!lane.run) begin
            next_st.phase = 4'h0;
         end else if ({1'b0, st.phase} >= lane.len - 5'h01) begin
            // >= so a shorter length never runs the phase through stale bits
            next_st.phase = 4'h0;
         end else begin
            next_st.phase = st.phase + 4'h1; // f-bit overwrites, pattern runs on
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign lane.dout = st.dout;
endmodule // ilc_tx_gen

// File: verilog/ilc_detector.sv
// repeating pattern detector with error tolerant integration
`include "ilc_params.svh"

module ilc_detector
   import ilc_pkg::*;
#(
   parameter int INTEG_BITS = `ILC_INTEG_BITS,
   parameter int ERR_MAX    = `ILC_INTEG_BITS / 32
)(
   input wire logic   mclk,
   input wire logic   rst,
   ilc_lane_if.det    lane
);
   localparam int CW = $clog2(INTEG_BITS + 1);

   typedef struct packed {
      ilc_det_state_t state;
      logic [15:0]    sr;
      logic [3:0]     phase;
      logic [CW-1:0]  bitCnt;
      logic [CW-1:0]  errCnt;
      logic           hit;
   } ilc_det_st_t;

   ilc_det_st_t st;
   ilc_det_st_t next_st;

   always_comb begin
      logic [15:0]   srN;
      logic [15:0]   pat;
      logic [15:0]   mask;
      logic          aligned;
      logic [CW-1:0] errN;
      srN     = {st.sr[14:0], lane.din};
      // top len bits only: short codes never see the second byte
      pat     = lane.code >> (5'h10 - lane.len);
      mask    = 16'hFFFF >> (5'h10 - lane.len);
      aligned = ((srN ^ pat) & mask) == 16'h0000;
      errN    = st.errCnt;
      next_st = st;
      if (!lane.run || lane.restart) begin
         next_st = '0;
      end else if (lane.stb) begin
         next_st.sr = srN;
         if (aligned) begin
            // re-align on every full match so f-bit slips are absorbed
            next_st.state = ILC_LOCK;
            next_st.phase = 4'h0;
         end else if (st.state == ILC_HUNT) begin
            errN = st.errCnt + CW'(1);
         end else begin
            if (lane.din != lane.code[4'hF - st.phase]) errN = st.errCnt + CW'(1);
            // wrap also when a length change left the phase past the new end
            if ({1'b0, st.phase} >= lane.len - 5'h01) next_st.phase = 4'h0;
            else next_st.phase = st.phase + 4'h1;
         end
         next_st.errCnt = errN;
         next_st.bitCnt = st.bitCnt + CW'(1);
         if (st.bitCnt == CW'(INTEG_BITS - 1)) begin
            next_st.hit    = (next_st.state == ILC_LOCK) && (errN <= CW'(ERR_MAX));
            next_st.bitCnt = '0;
            next_st.errCnt = '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   assign lane.dout = st.hit;
endmodule // ilc_detector

// File: verilog/ilc_inband_loop.sv
// in-band loop code generator and detectors with wishbone register slave
`include "ilc_params.svh"

module ilc_inband_loop
   import ilc_pkg::*;
#(
   parameter int INTEG_BITS = `ILC_INTEG_BITS,
   parameter int ERR_MAX    = `ILC_INTEG_BITS / 32
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [9:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output wire logic [31:0] wbDatR,
   output wire logic        wbAck,
   input  wire logic        txBitStb,
   input  wire logic        txFbitSlot,
   input  wire logic        txFbit,
   input  wire logic        txDataIn,
   output wire logic        txOut,
   input  wire logic        rxBitStb,
   input  wire logic        rxData
);
   typedef struct packed {
      logic [7:0] codeCtrl;
      logic [7:0] txFirst;
      logic [7:0] txSecond;
      logic [7:0] upFirst;
      logic [7:0] upSecond;
      logic [7:0] downFirst;
      logic [7:0] downSecond;
      logic [2:0] spareLen;
      logic [7:0] spareFirst;
      logic [7:0] spareSecond;
      logic       loopEn;
      logic       t1Mode;
      logic       noIns;
      logic       ack;
      logic [7:0] rdat;
   } ilc_top_st_t;

   ilc_top_st_t st;
   ilc_top_st_t next_st;

   logic       req;
   logic       wr;
   logic [7:0] idx;
   logic       loopRun;
   logic       upHit;
   logic       dnHit;
   logic       spHit;
   logic       upRestart;
   logic       dnRestart;
   logic       spRestart;

   ilc_lane_if txLane ();
   ilc_lane_if upLane ();
   ilc_lane_if dnLane ();
   ilc_lane_if spLane ();

   function automatic ilc_len_t rx_len(input logic [2:0] sel);
      // 111 means 8 or 16: both run as a 16-bit compare
      if (sel == 3'h7) rx_len = 5'h10;
      else rx_len = {2'b00, sel} + 5'h01;
   endfunction

   function automatic ilc_len_t tx_len(input logic [1:0] sel);
      case (sel)
         2'b00:   tx_len = 5'h05; // with 80h in the first byte this is loop-up
         2'b01:   tx_len = 5'h06; // a 3-bit code is written twice into 6 bits
         2'b10:   tx_len = 5'h07;
         default: tx_len = 5'h10;
      endcase
   endfunction

   assign req = wbCyc && wbStb && !st.ack;
   assign wr  = req && wbWe && wbSel[0];
   assign idx = wbAdr[9:2];

   always_comb begin
      next_st     = st;
      next_st.ack = req;
      if (req) begin
         next_st.rdat = 8'h00;
         if (idx == `ILC_IDX_CODE_CTRL) begin
            next_st.rdat = st.codeCtrl;
            if (wr) next_st.codeCtrl = wbDatW[7:0];
         end else if (idx == `ILC_IDX_TX_FIRST) begin
            next_st.rdat = st.txFirst;
            if (wr) next_st.txFirst = wbDatW[7:0];
         end else if (idx == `ILC_IDX_TX_SECOND) begin
            next_st.rdat = st.txSecond;
            if (wr) next_st.txSecond = wbDatW[7:0];
         end else if (idx == `ILC_IDX_UP_FIRST) begin
            next_st.rdat = st.upFirst;
            if (wr) next_st.upFirst = wbDatW[7:0];
         end else if (idx == `ILC_IDX_UP_SECOND) begin
            next_st.rdat = st.upSecond;
            if (wr) next_st.upSecond = wbDatW[7:0];
         end else if (idx == `ILC_IDX_DOWN_FIRST) begin
            next_st.rdat = st.downFirst;
            if (wr) next_st.downFirst = wbDatW[7:0];
         end else if (idx == `ILC_IDX_DOWN_SECOND) begin
            next_st.rdat = st.downSecond;
            if (wr) next_st.downSecond = wbDatW[7:0];
         end else if (idx == `ILC_IDX_SPARE_CTRL) begin
            // unused bits are not stored and read back zero
            next_st.rdat = {5'h00, st.spareLen};
            if (wr) next_st.spareLen = wbDatW[2:0];
         end else if (idx == `ILC_IDX_SPARE_FIRST) begin
            next_st.rdat = st.spareFirst;
            if (wr) next_st.spareFirst = wbDatW[7:0];
         end else if (idx == `ILC_IDX_SPARE_SECOND) begin
            next_st.rdat = st.spareSecond;
            if (wr) next_st.spareSecond = wbDatW[7:0];
         end else if (idx == `ILC_IDX_LOOP_CTRL) begin
            next_st.rdat = {7'h00, st.loopEn};
            if (wr) next_st.loopEn = wbDatW[`ILC_LOOP_EN_BIT];
         end else if (idx == `ILC_IDX_LINE_MODE) begin
            next_st.rdat = {6'h00, st.noIns, st.t1Mode};
            if (wr) begin
               next_st.t1Mode = wbDatW[`ILC_MODE_T1_BIT];
               next_st.noIns  = wbDatW[`ILC_MODE_NOINS_BIT];
            end
         end else if (idx == `ILC_IDX_STATUS_THREE) begin
            next_st.rdat[`ILC_STAT_UP_BIT]    = upHit;
            next_st.rdat[`ILC_STAT_DOWN_BIT]  = dnHit;
            next_st.rdat[`ILC_STAT_SPARE_BIT] = spHit;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) st <= '0;
      else st <= next_st;
   end

   // restart on either byte of a detector code, the pair forms one value
   assign upRestart = wr && (idx == `ILC_IDX_UP_FIRST || idx == `ILC_IDX_UP_SECOND);
   assign dnRestart = wr && (idx == `ILC_IDX_DOWN_FIRST || idx == `ILC_IDX_DOWN_SECOND);
   assign spRestart = wr && (idx == `ILC_IDX_SPARE_FIRST || idx == `ILC_IDX_SPARE_SECOND);

   assign loopRun = st.loopEn && st.t1Mode;

   // transmit lane
   assign txLane.code    = {st.txFirst, st.txSecond};
   assign txLane.len     = tx_len(st.codeCtrl[`ILC_TXLEN_LSB +: 2]);
   assign txLane.stb     = txBitStb;
   assign txLane.slot    = txFbitSlot && !st.noIns;
   assign txLane.din     = txLane.slot ? txFbit : txDataIn;
   assign txLane.run     = loopRun;
   assign txLane.restart = 1'b0;

   // receive lanes, one per detector
   assign upLane.code    = {st.upFirst, st.upSecond};
   assign upLane.len     = rx_len(st.codeCtrl[`ILC_UPLEN_LSB +: 3]);
   assign upLane.restart = upRestart;
   assign dnLane.code    = {st.downFirst, st.downSecond};
   assign dnLane.len     = rx_len(st.codeCtrl[`ILC_DNLEN_LSB +: 3]);
   assign dnLane.restart = dnRestart;
   assign spLane.code    = {st.spareFirst, st.spareSecond};
   assign spLane.len     = rx_len(st.spareLen);
   assign spLane.restart = spRestart;

   assign upLane.stb  = rxBitStb;
   assign upLane.din  = rxData;
   assign upLane.run  = st.t1Mode;
   assign upLane.slot = 1'b0;
   assign dnLane.stb  = rxBitStb;
   assign dnLane.din  = rxData;
   assign dnLane.run  = st.t1Mode;
   assign dnLane.slot = 1'b0;
   assign spLane.stb  = rxBitStb;
   assign spLane.din  = rxData;
   assign spLane.run  = st.t1Mode;
   assign spLane.slot = 1'b0;

   assign upHit = upLane.dout;
   assign dnHit = dnLane.dout;
   assign spHit = spLane.dout;

   ilc_tx_gen u_tx (
      .mclk (mclk),
      .rst  (rst),
      .lane (txLane)
   );

   // three independent detectors
   ilc_detector #(.INTEG_BITS(INTEG_BITS), .ERR_MAX(ERR_MAX)) u_up (
      .mclk (mclk),
      .rst  (rst),
      .lane (upLane)
   );

   ilc_detector #(.INTEG_BITS(INTEG_BITS), .ERR_MAX(ERR_MAX)) u_down (
      .mclk (mclk),
      .rst  (rst),
      .lane (dnLane)
   );

   ilc_detector #(.INTEG_BITS(INTEG_BITS), .ERR_MAX(ERR_MAX)) u_spare (
      .mclk (mclk),
      .rst  (rst),
      .lane (spLane)
   );

   assign wbAck  = st.ack;
   assign wbDatR = {24'h000000, st.rdat};
   assign txOut  = txLane.dout;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_ack_pulse;
      wbAck |=> !wbAck;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_ack_latency;
      (wbCyc && wbStb && !wbAck) |=> wbAck;
   endproperty
   a_ack_latency: assert property (p_ack_latency)
      else $error("request not answered in one cycle");

   property p_ctrl_reset;
      $fell(rst) |-> (st.codeCtrl == 8'h00 && !st.loopEn);
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("code control not zero after reset");

   property p_ctrl_write;
      (wr && idx == `ILC_IDX_CODE_CTRL) |=> st.codeCtrl == $past(wbDatW[7:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("code control write lost");

   property p_pass;
      (txBitStb && !loopRun && !txFbitSlot) |=> txOut == $past(txDataIn);
   endproperty
   a_pass: assert property (p_pass)
      else $error("pattern sent while loop disabled");

   property p_fbit;
      (txBitStb && txFbitSlot && !st.noIns) |=> txOut == $past(txFbit);
   endproperty
   a_fbit: assert property (p_fbit)
      else $error("framing bit not placed in its slot");

   property p_t1_off;
      !st.t1Mode |=> (!upHit && !dnHit && !spHit);
   endproperty
   a_t1_off: assert property (p_t1_off)
      else $error("detector active outside T1 mode");

   property p_restart;
      upRestart |=> !upHit ##1 !upHit;
   endproperty
   a_restart: assert property (p_restart)
      else $error("up detector not restarted by code write");

   property p_txlen;
      (st.codeCtrl[7:6] == 2'b00) |-> txLane.len == 5'h05;
   endproperty
   a_txlen: assert property (p_txlen)
      else $error("tx length 00 is not five bits");

   property p_status_read;
      (req && !wbWe && idx == `ILC_IDX_STATUS_THREE)
         |=> wbDatR[7:5] == $past({spHit, dnHit, upHit});
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read does not show detectors");
endmodule // ilc_inband_loop

// File: testbench/ilc_far_end.sv
// far end model: receive bit source, transmit strobes and transmit bit recorder
module ilc_far_end (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [15:0] rxCode,
   input  wire logic [4:0]  rxLen,
   input  wire logic [7:0]  errEvery,
   input  wire logic        txOut,
   output logic             rxBitStb,
   output logic             rxData,
   output logic             txBitStb,
   output logic             txFbitSlot,
   output logic             txFbit,
   output logic [31:0]      txHist,
   output logic [15:0]      fSeen,
   output logic [15:0]      fBad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div;
   logic [4:0] phase;
   logic [7:0] errCnt;
   logic [7:0] fPos;
   always_ff @(posedge mclk) begin
      if (rst) begin
         {div, phase, errCnt, fPos} <= '0;
         {rxBitStb, rxData, txBitStb, txFbitSlot, txFbit} <= '0;
         {txHist, fSeen, fBad} <= '0;
      end else begin
         div      <= div + 2'h1;
         rxBitStb <= (div == 2'h0);
         txBitStb <= (div == 2'h2);
         if (div == 2'h0) begin
            phase  <= (phase + 5'h1 >= rxLen) ? 5'h0 : phase + 5'h1;
            errCnt <= (errCnt + 8'h1 >= errEvery) ? 8'h0 : errCnt + 8'h1;
            // length 0 sends an alternating filler that matches none of the codes the detector checks program
            rxData <= ((rxLen == 5'h0) ? ~rxData : rxCode[15 - phase])
                      ^ (errEvery != 8'h0 && errCnt == 8'h0);
         end
         if (div == 2'h2) begin
            fPos       <= (fPos == 8'hC0) ? 8'h00 : fPos + 8'h01;
            txFbitSlot <= (fPos == 8'hC0);
            if (fPos == 8'hC0)
               txFbit <= ~txFbit;
            // txOut now holds the bit of the previous strobe
            txHist <= {txHist[30:0], txOut};
            if (txFbitSlot) begin
               fSeen <= fSeen + 16'h0001;
               if (txOut !== txFbit)
                  fBad <= fBad + 16'h0001;
            end
         end
      end
   end
endmodule // ilc_far_end

// File: testbench/testbench.sv
// self-checking bench for the in-band loop code block
`include "ilc_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst, wbCyc, wbStb, wbWe, wbAck, txDataIn, txOut;
   logic        rxBitStb, rxData, txBitStb, txFbitSlot, txFbit;
   logic [9:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW, wbDatR, txHist;
   logic [15:0] rxCode, fSeen, fBad, s0, b0;
   logic [4:0]  rxLen;
   logic [7:0]  errEvery, q;
   int          failures, comparisons;
   logic [7:0]  txCtl [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
   logic [15:0] txCd [4] = '{16'h8000, 16'hB400, 16'hCA00, 16'h9C36};
   int          txL [4] = '{5, 6, 7, 16};
   logic [15:0] rxC [3] = '{16'h8000, 16'hA53C, 16'hC000};
   logic [4:0]  rxL [3] = '{5'h05, 5'h10, 5'h03};
   logic [7:0]  rxE [3] = '{8'h64, 8'h00, 8'h00};
   logic [7:0]  rxS [3] = '{8'h20, 8'h40, 8'h80};

   ilc_inband_loop #(.INTEG_BITS(200), .ERR_MAX(6)) u_dut (
      .mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .txBitStb(txBitStb), .txFbitSlot(txFbitSlot), .txFbit(txFbit),
      .txDataIn(txDataIn), .txOut(txOut), .rxBitStb(rxBitStb), .rxData(rxData));
   ilc_far_end u_far (
      .mclk(mclk), .rst(rst), .rxCode(rxCode), .rxLen(rxLen), .errEvery(errEvery),
      .txOut(txOut), .rxBitStb(rxBitStb), .rxData(rxData), .txBitStb(txBitStb),
      .txFbitSlot(txFbitSlot), .txFbit(txFbit), .txHist(txHist), .fSeen(fSeen),
      .fBad(fBad));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task close_out;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one classic cycle; ack is taken at the edge where it is sampled high
   task xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
             input logic [3:0] sel);
      @(posedge mclk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= {idx, 2'b00};
      wbSel  <= sel;
      wbDatW <= {24'h000000, d};
      // only the watchdog ends a wait that never sees ack
      do begin
         @(posedge mclk);
      end while (wbAck !== 1'b1);
      q = wbDatR[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, 4'hF);
   endtask

   task rdc(input string name, input logic [7:0] idx, input logic [7:0] mask,
            input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00, 4'hF);
      check(name, {24'h000000, q & mask}, {24'h000000, exp});
   endtask

   task pause(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // true when the newest 32 line bits are the code repeated at some phase
   function automatic logic fits(logic [31:0] h, logic [15:0] c, int l);
      logic ok;
      for (int p = 0; p < l; p++) begin
         ok = 1'b1;
         for (int k = 0; k < 32; k++)
            if (h[k] !== c[15 - ((p + 32 * l - k) % l)])
               ok = 1'b0;
         if (ok)
            return 1'b1;
      end
      return 1'b0;
   endfunction

   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      close_out();
   end

   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW, txDataIn} = '0;
      {rxCode, rxLen, errEvery} = '0;
      rst = 1'b1;
      pause(20);
      rst <= 1'b0;
      pause(1);
      rdc("code control reset", `ILC_IDX_CODE_CTRL, 8'hFF, 8'h00);
      wr(`ILC_IDX_CODE_CTRL, 8'hA5);
      xfer(1'b1, `ILC_IDX_CODE_CTRL, 8'h11, 4'h0);
      rdc("code control rw", `ILC_IDX_CODE_CTRL, 8'hFF, 8'hA5);
      rdc("unmapped read", 8'h10, 8'hFF, 8'h00);
      wr(`ILC_IDX_SPARE_CTRL, 8'hFF);
      rdc("spare control width", `ILC_IDX_SPARE_CTRL, 8'hFF, 8'h07);
      // t1 mode without framing insertion keeps the recorded stream purely periodic
      wr(`ILC_IDX_LINE_MODE, 8'h03);
      wr(`ILC_IDX_LOOP_CTRL, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(`ILC_IDX_TX_FIRST, txCd[i][15:8]);
         wr(`ILC_IDX_TX_SECOND, txCd[i][7:0]);
         wr(`ILC_IDX_CODE_CTRL, txCtl[i]);
         pause(200);
         check("tx pattern", {31'h0, fits(txHist, txCd[i], txL[i])}, 1);
      end
      txDataIn <= 1'b1;
      wr(`ILC_IDX_LOOP_CTRL, 8'h00);
      pause(200);
      check("tx after loop off", txHist, 32'hFFFFFFFF);
      wr(`ILC_IDX_LOOP_CTRL, 8'h01);
      wr(`ILC_IDX_LINE_MODE, 8'h02);
      pause(200);
      check("tx outside t1", txHist, 32'hFFFFFFFF);
      txDataIn <= 1'b0;
      wr(`ILC_IDX_LINE_MODE, 8'h01);
      pause(20);
      s0 = fSeen;
      b0 = fBad;
      pause(2400);
      check("framing slots seen", {31'h0, (fSeen - s0) >= 16'h0002}, 1);
      check("framing slot value", {16'h0, fBad - b0}, 0);
      wr(`ILC_IDX_LOOP_CTRL, 8'h00);
      wr(`ILC_IDX_CODE_CTRL, 8'hE7);
      wr(`ILC_IDX_UP_FIRST, 8'h80);
      wr(`ILC_IDX_UP_SECOND, 8'h5A);
      wr(`ILC_IDX_DOWN_FIRST, 8'hA5);
      wr(`ILC_IDX_DOWN_SECOND, 8'h3C);
      wr(`ILC_IDX_SPARE_CTRL, 8'h02);
      wr(`ILC_IDX_SPARE_FIRST, 8'hC0);
      wr(`ILC_IDX_SPARE_SECOND, 8'hFF);
      for (int i = 0; i < 3; i++) begin
         rxCode   <= rxC[i];
         rxLen    <= rxL[i];
         errEvery <= rxE[i];
         pause(2400);
         rdc("detector status", `ILC_IDX_STATUS_THREE, 8'hE0, rxS[i]);
      end
      wr(`ILC_IDX_SPARE_FIRST, 8'hC0);
      rdc("status after restart", `ILC_IDX_STATUS_THREE, 8'hE0, 8'h00);
      pause(2400);
      rdc("status relocked", `ILC_IDX_STATUS_THREE, 8'hE0, 8'h80);
      wr(`ILC_IDX_LINE_MODE, 8'h00);
      pause(20);
      rdc("status outside t1", `ILC_IDX_STATUS_THREE, 8'hE0, 8'h00);
      close_out();
   end
endmodule // testbench
